// >>> verilog/mxm_pkg.sv
// How it works
// - mode 00 sends every external data move to on-chip RAM, aliased.
// - mode 01 sends addresses below 2 kB on-chip and the rest off-chip.
// - mode 01 8-bit off-chip moves leave the upper byte to the port latch.
// - mode 10 sends addresses below 2 kB on-chip and the rest off-chip.
// - mode 10 8-bit off-chip moves drive the page value as upper byte.
// - mode 11 sends every move off-chip and hides on-chip RAM.
// - the strobe width field counts only while the mode high bit is zero.
// - strobe high and low times each last width field plus one cycles while the mode high bit is zero, one cycle when it is set.
// - data and the low address byte share the same eight pins.
// - first phase holds the latch strobe high with the low address out.
// - the data bus owns the shared pins while read or write is asserted.
// - pins acting as inputs have their drivers off during the move.
package mxm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] MXM_OFS_CONFIG = 8'h00;
  localparam logic [7:0] MXM_OFS_PAGE = 8'h04;
  localparam logic [7:0] MXM_OFS_STATUS = 8'h08;
  localparam logic [7:0] MXM_OFS_RDATA = 8'h0C;

  // ==========================================================
  // fields and reset values
  localparam int MXM_CFG_WIDTH_LSB = 0;
  localparam int MXM_CFG_MODE_LSB = 2;
  localparam int MXM_CFG_MODE_HIGH = 3;
  localparam logic [7:0] MXM_CONFIG_RESET = 8'h03;
  localparam logic [7:0] MXM_PAGE_RESET = 8'h00;

  // ==========================================================
  // modes and address split
  localparam logic [1:0] MXM_MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MXM_MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MXM_MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MXM_MODE_EXTERNAL = 2'h3;
  localparam int MXM_ONCHIP_ADDR_BITS = 11;

  // ==========================================================
  // cycle counts
  localparam logic [2:0] MXM_ALE_FIXED_LOAD = 3'h0;
  localparam logic [2:0] MXM_STROBE_LOAD = 3'h3;
  localparam int MXM_SYNC_STAGES = 2;

  // ==========================================================
  // sequencer states, gray along the off-chip path except the hold to idle step
  typedef enum logic [2:0] {
    MXM_IDLE = 3'b000,
    MXM_ALE_HIGH = 3'b001,
    MXM_ALE_LOW = 3'b011,
    MXM_STROBE = 3'b010,
    MXM_HOLD = 3'b110,
    MXM_ONCHIP = 3'b100
  } mxm_state_t;

endpackage

// >>> verilog/mxm_pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the shared data pins
module mxm_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] firstStage;

  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      firstStage <= '0;
      syncOut <= '0;
    end else begin
      firstStage <= pinIn;
      syncOut <= firstStage;
    end
  end
endmodule

// >>> verilog/mxm_phase_timer.sv
`timescale 1ns/1ps
// down counter that times one bus phase
module mxm_phase_timer #(
  parameter int WIDTH = 3
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic expired
);
  logic [WIDTH-1:0] count;

  // load on phase entry, then count down to zero and stay
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign expired = (count == '0);
endmodule

// >>> verilog/mxm_ext_memory_if.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module mxm_ext_memory_if
  import mxm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external data move requests from the core
  input wire logic movReq,
  input wire logic movWrite,
  input wire logic movWide,
  input wire logic [15:0] movAddr,
  input wire logic [7:0] movWdata,
  output logic movBusy,
  output logic movDone,
  output logic [7:0] movRdata,
  // on-chip data ram
  output logic ramReq,
  output logic ramWrite,
  output logic [MXM_ONCHIP_ADDR_BITS-1:0] ramAddr,
  output logic [7:0] ramWdata,
  input wire logic [7:0] ramRdata,
  // multiplexed pins
  input wire logic [7:0] adIn,
  output logic [7:0] adOut,
  output logic adOe,
  output logic [7:0] addrHighOut,
  output logic addrHighOe,
  output logic ale,
  output logic readStrobe_n,
  output logic writeStrobe_n,
  output logic pinsClaimed
);

  // ==========================================================
  // configuration registers
  logic [7:0] extMemoryConfig;
  logic [7:0] xramPageSelect;
  logic [7:0] lastReadData;
  logic lastOffChip;
  logic [1:0] memoryMapMode;
  logic mapModeHighBit;
  logic [1:0] latchStrobeWidthSel;

  assign memoryMapMode = extMemoryConfig[MXM_CFG_MODE_LSB +: 2];
  assign mapModeHighBit = extMemoryConfig[MXM_CFG_MODE_HIGH];
  assign latchStrobeWidthSel = extMemoryConfig[MXM_CFG_WIDTH_LSB +: 2];

  // ==========================================================
  // apb access decode
  logic apbWrite;
  logic addrMapped;

  // zero wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign apbWrite = psel && penable && pwrite;
  assign addrMapped = (paddr == MXM_OFS_CONFIG) || (paddr == MXM_OFS_PAGE)
    || (paddr == MXM_OFS_STATUS) || (paddr == MXM_OFS_RDATA);
  assign pslverr = psel && penable && !addrMapped;

  // config: only mode and width bits stored, reserved and unused read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      extMemoryConfig <= MXM_CONFIG_RESET;
    end else if (apbWrite && paddr == MXM_OFS_CONFIG) begin
      extMemoryConfig <= {4'h0, pwdata[3:0]};
    end
  end

  // page select, upper byte of 8-bit moves
  always_ff @(posedge clock) begin
    if (reset) begin
      xramPageSelect <= MXM_PAGE_RESET;
    end else if (apbWrite && paddr == MXM_OFS_PAGE) begin
      xramPageSelect <= pwdata[7:0];
    end
  end

  // ==========================================================
  // sequencer
  mxm_state_t state;
  mxm_state_t next_state;
  logic phaseExpired;
  logic phaseLoad;
  logic [2:0] phaseLoadValue;
  logic [2:0] aleLoad;
  logic [15:0] effAddr;
  logic goOffChip;
  logic driveHigh;
  logic [7:0] highByte;
  logic [7:0] syncAd;

  // read back captured in the setup cycle, so prdata is a flop and
  // the access still needs no wait state
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          MXM_OFS_CONFIG: prdata <= {24'h00_0000, extMemoryConfig};
          MXM_OFS_PAGE: prdata <= {24'h00_0000, xramPageSelect};
          MXM_OFS_STATUS: prdata <= {27'h000_0000, state, lastOffChip,
                                     movBusy};
          MXM_OFS_RDATA: prdata <= {24'h00_0000, lastReadData};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // 8-bit moves take the page as upper byte, 16-bit the full address
  assign effAddr = movWide ? movAddr : {xramPageSelect, movAddr[7:0]};

  // route the move by mode and by the 2 kB split
  always_comb begin
    goOffChip = 1'b0;
    unique case (memoryMapMode)
      MXM_MODE_INTERNAL: goOffChip = 1'b0;
      // a low page keeps an 8-bit move on-chip
      MXM_MODE_SPLIT_NOBANK: goOffChip =
        (effAddr[15:MXM_ONCHIP_ADDR_BITS] != '0);
      MXM_MODE_SPLIT_BANK: goOffChip =
        (effAddr[15:MXM_ONCHIP_ADDR_BITS] != '0);
      MXM_MODE_EXTERNAL: goOffChip = 1'b1;
      default: goOffChip = 1'b0;
    endcase
  end

  // upper byte: 16-bit drives it, mode 10 drives the page,
  // 8-bit moves in 01 and 11 leave the port latch in charge
  always_comb begin
    driveHigh = 1'b1;
    highByte = effAddr[15:8];
    if (!movWide) begin
      if (memoryMapMode == MXM_MODE_SPLIT_BANK) begin
        highByte = xramPageSelect;
      end else begin
        driveHigh = 1'b0;
        highByte = 8'h00;
      end
    end
  end

  // width field counts only while mode high bit is clear
  assign aleLoad = mapModeHighBit ? MXM_ALE_FIXED_LOAD
    : {1'b0, latchStrobeWidthSel};

  always_comb begin
    next_state = state;
    unique case (state)
      MXM_IDLE: begin
        if (movReq) begin
          next_state = goOffChip ? MXM_ALE_HIGH : MXM_ONCHIP;
        end
      end
      MXM_ONCHIP: next_state = MXM_IDLE;
      MXM_ALE_HIGH: begin
        if (phaseExpired) begin
          next_state = MXM_ALE_LOW;
        end
      end
      MXM_ALE_LOW: begin
        if (phaseExpired) begin
          next_state = MXM_STROBE;
        end
      end
      MXM_STROBE: begin
        if (phaseExpired) begin
          next_state = MXM_HOLD;
        end
      end
      MXM_HOLD: next_state = MXM_IDLE;
      default: next_state = MXM_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= MXM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // timer reloads on each phase entry: n cycles means load n-1
  assign phaseLoad = (next_state != state);
  always_comb begin
    phaseLoadValue = 3'h0;
    if (next_state == MXM_ALE_HIGH || next_state == MXM_ALE_LOW) begin
      phaseLoadValue = aleLoad;
    end else if (next_state == MXM_STROBE) begin
      phaseLoadValue = MXM_STROBE_LOAD;
    end
  end

  mxm_phase_timer #(
    .WIDTH(3)
  ) phaseTimer (
    .clock(clock),
    .reset(reset),
    .load(phaseLoad),
    .loadValue(phaseLoadValue),
    .expired(phaseExpired)
  );

  mxm_pin_sync #(
    .WIDTH(8)
  ) adSync (
    .clock(clock),
    .reset(reset),
    .pinIn(adIn),
    .syncOut(syncAd)
  );

  // ==========================================================
  // captured move
  logic moveWrite;
  logic [7:0] moveData;
  logic [7:0] moveLow;

  // request fields held for the whole move
  always_ff @(posedge clock) begin
    if (reset) begin
      moveWrite <= 1'b0;
      moveData <= 8'h00;
      moveLow <= 8'h00;
      lastOffChip <= 1'b0;
    end else if (state == MXM_IDLE && movReq) begin
      moveWrite <= movWrite;
      moveData <= movWdata;
      moveLow <= effAddr[7:0];
      lastOffChip <= goOffChip;
    end
  end

  // ==========================================================
  // shared pins, registered from the next state to stay glitch free
  always_ff @(posedge clock) begin
    if (reset) begin
      adOut <= 8'h00;
      adOe <= 1'b0;
      ale <= 1'b0;
      readStrobe_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      pinsClaimed <= 1'b0;
    end else begin
      adOut <= 8'h00;
      adOe <= 1'b0;
      ale <= 1'b0;
      readStrobe_n <= 1'b1;
      writeStrobe_n <= 1'b1;
      pinsClaimed <= 1'b0;
      unique case (next_state)
        MXM_ALE_HIGH: begin
          // latch is transparent, low address on the shared pins
          adOut <= (state == MXM_IDLE) ? effAddr[7:0] : moveLow;
          adOe <= 1'b1;
          ale <= 1'b1;
          pinsClaimed <= 1'b1;
        end
        MXM_ALE_LOW: begin
          // address kept through the fall so the latch freezes it
          adOut <= moveLow;
          adOe <= 1'b1;
          pinsClaimed <= 1'b1;
        end
        MXM_STROBE: begin
          // data owns the pins; on reads the memory drives them
          adOut <= moveWrite ? moveData : 8'h00;
          adOe <= moveWrite;
          readStrobe_n <= moveWrite;
          writeStrobe_n <= !moveWrite;
          pinsClaimed <= 1'b1;
        end
        MXM_HOLD: begin
          // write data held one cycle past the strobe edge
          adOut <= moveWrite ? moveData : 8'h00;
          adOe <= moveWrite;
          pinsClaimed <= 1'b1;
        end
        default: begin
          pinsClaimed <= 1'b0;
        end
      endcase
    end
  end

  // upper address pins, set at move start and held to its end
  always_ff @(posedge clock) begin
    if (reset) begin
      addrHighOut <= 8'h00;
      addrHighOe <= 1'b0;
    end else if (state == MXM_IDLE && movReq && goOffChip) begin
      addrHighOut <= highByte;
      addrHighOe <= driveHigh;
    end else if (next_state == MXM_IDLE || next_state == MXM_ONCHIP) begin
      addrHighOut <= 8'h00;
      addrHighOe <= 1'b0;
    end
  end

  // ==========================================================
  // on-chip ram port, low 11 bits so larger addresses alias
  always_ff @(posedge clock) begin
    if (reset) begin
      ramReq <= 1'b0;
      ramWrite <= 1'b0;
      ramAddr <= '0;
      ramWdata <= 8'h00;
    end else if (state == MXM_IDLE && movReq && !goOffChip) begin
      ramReq <= 1'b1;
      ramWrite <= movWrite;
      ramAddr <= effAddr[MXM_ONCHIP_ADDR_BITS-1:0];
      ramWdata <= movWdata;
    end else begin
      ramReq <= 1'b0;
      ramWrite <= 1'b0;
    end
  end

  // ==========================================================
  // completion and read data
  // the synchroniser lags two cycles, so data is sampled at the
  // strobe's last cycle; the strobe is four cycles to cover that
  always_ff @(posedge clock) begin
    if (reset) begin
      movDone <= 1'b0;
      movRdata <= 8'h00;
      lastReadData <= 8'h00;
    end else begin
      movDone <= 1'b0;
      if (state == MXM_ONCHIP) begin
        movDone <= 1'b1;
        if (!moveWrite) begin
          movRdata <= ramRdata;
          lastReadData <= ramRdata;
        end
      end else if (state == MXM_HOLD) begin
        movDone <= 1'b1;
      end
      if (state == MXM_STROBE && phaseExpired && !moveWrite) begin
        movRdata <= syncAd;
        lastReadData <= syncAd;
      end
    end
  end

  assign movBusy = (state != MXM_IDLE);

endmodule

// >>> sim/mxm_ext_memory_if_sva.sv
`timescale 1ns/1ps
module mxm_ext_memory_if_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic movReq,
  input wire logic movBusy,
  input wire logic movDone,
  input wire logic ramReq,
  input wire logic pinsClaimed,
  input wire logic [7:0] adOut,
  input wire logic adOe,
  input wire logic addrHighOe,
  input wire logic ale,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n
);
  logic aleQ;
  logic [2:0] hiCnt;
  logic [2:0] loCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ==========================================
  // phase length counters
  // low count restarts at each fall, so idle time never leaks in
  always_ff @(posedge clock) begin
    if (reset) begin
      aleQ <= 1'b0;
      hiCnt <= 3'h0;
      loCnt <= 3'h0;
    end else begin
      aleQ <= ale;
      if (ale) hiCnt <= aleQ ? hiCnt + 3'h1 : 3'h1;
      if (!ale) loCnt <= aleQ ? 3'h1 : loCnt + 3'h1;
    end
  end

  // ==========================================
  // assertions
  ale_drives_a: assert property (ale |-> adOe && pinsClaimed)
    else $error("latch strobe high without address driven");
  ale_addr_hold_a: assert property (
    ale && $past(ale) |-> $stable(adOut))
    else $error("low address moved while latch open");
  read_release_a: assert property (!readStrobe_n |-> !adOe)
    else $error("shared pins driven during read strobe");
  write_drive_a: assert property (
    !writeStrobe_n && !$past(writeStrobe_n) |-> adOe && $stable(adOut))
    else $error("write data not held on shared pins");
  strobe_no_ale_a: assert property (
    (!readStrobe_n || !writeStrobe_n) |-> !ale && pinsClaimed)
    else $error("strobe overlaps address phase");
  ale_high_max_a: assert property ($rose(ale) |-> ##[1:4] !ale)
    else $error("latch strobe high too long");
  phase_equal_a: assert property (
    ($fell(readStrobe_n) || $fell(writeStrobe_n)) |-> loCnt == hiCnt)
    else $error("strobe high and low times differ");
  strobe_len_a: assert property (
    $fell(readStrobe_n) |-> !readStrobe_n[*4] ##1 readStrobe_n)
    else $error("read strobe width wrong");
  onchip_quiet_a: assert property (ramReq |-> !pinsClaimed && !ale)
    else $error("on-chip access touched the pins");
  high_own_a: assert property (addrHighOe |-> pinsClaimed)
    else $error("upper byte driven outside a move");
  done_pulse_a: assert property (movDone |=> !movDone)
    else $error("done longer than one cycle");
  take_busy_a: assert property (movReq && !movBusy |=> movBusy)
    else $error("request not taken");

  cover property ($fell(readStrobe_n));
  cover property ($fell(writeStrobe_n));
  cover property (ramReq);
  cover property ($rose(ale) ##1 ale ##1 ale ##1 ale);
endmodule

bind mxm_ext_memory_if mxm_ext_memory_if_sva u_sva (
  .clock(clock), .reset(reset), .movReq(movReq), .movBusy(movBusy),
  .movDone(movDone), .ramReq(ramReq), .pinsClaimed(pinsClaimed),
  .adOut(adOut), .adOe(adOe), .addrHighOe(addrHighOe), .ale(ale),
  .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n));

// >>> sim/mxm_ext_mem.sv
`timescale 1ns/1ps
module mxm_ext_mem (
  input wire logic [7:0] adBus,
  input wire logic [7:0] highBus,
  input wire logic ale,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  output logic [7:0] memOut,
  output logic [15:0] lastAddr
);
  logic [7:0] lowLatch;
  logic [7:0] held;
  logic [15:0] liveAddr;
  logic [7:0] mem [0:65535];

  // transparent while high, frozen from the fall
  always_latch begin
    if (ale) lowLatch <= adBus;
  end
  assign liveAddr = {highBus, lowLatch};

  // address kept from the strobe, the upper pins are released later
  always @(negedge readStrobe_n or negedge writeStrobe_n) begin
    lastAddr <= liveAddr;
  end

  // write data taken as the strobe ends
  always @(posedge writeStrobe_n) mem[liveAddr] <= adBus;

  // read data only under the strobe, else a changed level
  always @(posedge readStrobe_n) held <= mem[liveAddr];
  assign memOut = readStrobe_n ? ~held : mem[liveAddr];
endmodule

// >>> sim/mxm_ext_memory_if_tb_top.sv
`timescale 1ns/1ps
module mxm_ext_memory_if_tb_top;
  import mxm_pkg::*;
  logic clock;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic movReq = 1'b0, movWrite = 1'b0, movWide = 1'b0;
  logic [7:0] paddr = 8'h00, movWdata = 8'h00;
  logic [7:0] ramRdata;
  logic [7:0] portHigh = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] movAddr = 16'h0, lastAddr;
  logic pready, pslverr, movBusy, movDone, ramReq, ramWrite;
  logic adOe, addrHighOe, ale, readStrobe_n, writeStrobe_n, pinsClaimed;
  logic [7:0] movRdata, ramWdata, adOut, adIn, addrHighOut, memOut, hiBus;
  logic [10:0] ramAddr;
  logic [7:0] ram [0:2047];
  int fail_count = 0, n_checks = 0, ramCnt = 0, pinCnt = 0;

  assign adIn = adOe ? adOut : memOut;
  assign hiBus = addrHighOe ? addrHighOut : portHigh;

  mxm_ext_memory_if u_mxm_ext_memory_if (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .movReq(movReq), .movWrite(movWrite), .movWide(movWide),
    .movAddr(movAddr), .movWdata(movWdata), .movBusy(movBusy),
    .movDone(movDone), .movRdata(movRdata), .ramReq(ramReq),
    .ramWrite(ramWrite), .ramAddr(ramAddr), .ramWdata(ramWdata),
    .ramRdata(ramRdata), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .addrHighOut(addrHighOut), .addrHighOe(addrHighOe), .ale(ale),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .pinsClaimed(pinsClaimed));
  mxm_ext_mem u_mxm_ext_mem (.adBus(adIn), .highBus(hiBus), .ale(ale),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .memOut(memOut), .lastAddr(lastAddr));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================
  // on-chip ram answers within the ramReq cycle, plus route counters
  assign ramRdata = ram[ramAddr];
  always @(posedge clock) begin
    if (ramReq === 1'b1) begin
      if (ramWrite) ram[ramAddr] <= ramWdata;
      ramCnt++;
    end
    if (pinsClaimed === 1'b1) pinCnt++;
  end

  // ==========================================
  // bus tasks and checks
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t register access never ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // request held for the taking edge only, so it is not taken twice
  task automatic mov(input logic wr, wide, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] rd, output int n, r, p);
    int r0, p0;
    @(posedge clock);
    movReq <= 1'b1; movWrite <= wr; movWide <= wide;
    movAddr <= a; movWdata <= d;
    @(posedge clock);
    movReq <= 1'b0;
    r0 = ramCnt; p0 = pinCnt; n = 0;
    do begin @(posedge clock); #1; n++; end
    while (movDone !== 1'b1 && n < 40);
    rd = movRdata; r = ramCnt - r0; p = pinCnt - p0;
  endtask

  task automatic chk_reg(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t register got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_mov(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t move got %h want %h", $time, g, e);
    end
  endtask

  function automatic int lat(logic [1:0] m, w, logic off);
    return off ? 2 * (m[1] ? 1 : int'(w) + 1) + 5 : 1;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    fail_count++;
    test_done;
  end

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic err, off, wide;
    logic [7:0] r8, page, hi, d;
    logic [15:0] a, eff;
    logic [1:0] m, w;
    int n, rc, pc;
    void'($urandom(32'h189A133A));
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, MXM_OFS_CONFIG, 32'h0, rd, err);
    chk_reg(rd, 32'h3);
    apb(1'b0, MXM_OFS_PAGE, 32'h0, rd, err);
    chk_reg(rd, 32'h0);
    apb(1'b1, 8'h10, 32'hFF, rd, err);
    chk_reg({31'h0, err}, 32'h1);
    apb(1'b1, MXM_OFS_CONFIG, 32'hF6, rd, err);
    apb(1'b0, MXM_OFS_CONFIG, 32'h0, rd, err);
    chk_reg(rd, 32'h6);
    // every mode with every width, random addresses and pages
    for (int i = 0; i < 64; i++) begin
      m = i[1:0]; w = i[3:2];
      wide = 1'($urandom); d = 8'($urandom); hi = 8'($urandom);
      a = 16'($urandom);
      page = ($urandom % 2) ? 8'($urandom) : 8'($urandom % 16);
      apb(1'b1, MXM_OFS_CONFIG, {28'h0, m, w}, rd, err);
      apb(1'b1, MXM_OFS_PAGE, {24'h0, page}, rd, err);
      portHigh <= hi;
      eff = wide ? a : {page, a[7:0]};
      off = (m == 2'h3) || (m != 2'h0 && eff >= 16'h0800);
      mov(1'b1, wide, a, d, r8, n, rc, pc);
      chk_mov(n, lat(m, w, off));
      chk_mov({31'h0, pc != 0}, {31'h0, off});
      chk_mov({31'h0, rc != 0}, {31'h0, !off});
      if (off) chk_mov(lastAddr,
        {(wide || m == 2'h2) ? eff[15:8] : hi, eff[7:0]});
      // mode 00 16-bit moves read back through an alias, bits 15:11 flipped
      mov(1'b0, wide, (m == 2'h0 && wide) ? a ^ 16'hF800 : a, 8'h00,
        r8, n, rc, pc);
      chk_mov({24'h0, r8}, {24'h0, d});
      apb(1'b0, MXM_OFS_RDATA, 32'h0, rd, err);
      chk_reg(rd, {24'h0, d});
      apb(1'b0, MXM_OFS_STATUS, 32'h0, rd, err);
      chk_reg(rd, {30'h0, off, 1'b0});
    end
    test_done;
  end
endmodule
